// ==== hw/fcl_loader.sv ====
// configuration loader: self-load with cold boot select, and serial peripheral mode
`timescale 1ns/10ps
`default_nettype none
module fcl_loader
  import fcl_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         spi_sck,
  input  wire logic         spi_mosi,
  output logic              spi_so_o,
  output logic              spi_so_oe,
  input  wire logic         config_reset_n,
  input  wire logic [1:0]   boot_image_select,
  input  wire fcl_src_t     boot_source,
  input  wire logic [23:0]  image_length,
  output fcl_mem_req_t      mem_cmd,
  input  wire fcl_byte_t    mem_rsp,
  output fcl_byte_t         cfg_out,
  output logic              cfg_clear,
  output logic              config_done_o,
  output logic              config_done_oe,
  output logic              user_spi_enable
);

  fcl_state_t  state_reg;
  fcl_src_t    src_reg;
  logic [2:0]  pins_s;
  logic        rst_n_s;
  logic [1:0]  sel_s;
  logic [1:0]  sel_reg;
  logic [1:0]  vec_idx_reg;
  logic [15:0] start_reg;
  logic [23:0] addr_reg;
  logic [23:0] byte_cnt_reg;
  logic        pend_reg;
  logic        link_rst_reg;
  logic [1:0]  from_link_s;
  logic        tog_prev_reg;
  logic        link_byte;
  logic        last_byte;
  logic        cold_en;
  logic [23:0] vec_addr;
  fcl_byte_t   cfg_next;

  // link-domain state
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic        synced_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  hold_reg;
  logic        tog_reg;
  logic        done_s;
  logic [5:0]  trail_cnt_reg;
  logic        handoff_reg;

  fcl_sync #(.W(3)) u_pin_sync (
    .clk  (clk),
    .arst (1'b0),
    .srst (srst),
    .d    ({config_reset_n, boot_image_select}),
    .q    (pins_s)
  );
  assign rst_n_s = pins_s[2];
  assign sel_s   = pins_s[1:0];

  // byte toggle and handoff level coming back from the link clock
  fcl_sync #(.W(2)) u_link_sync (
    .clk  (clk),
    .arst (1'b0),
    .srst (srst),
    .d    ({handoff_reg, tog_reg}),
    .q    (from_link_s)
  );

  fcl_sync #(.W(1)) u_done_sync (
    .clk  (spi_sck),
    .arst (link_rst_reg),
    .srst (1'b0),
    .d    (state_reg == FCL_ST_DONE),
    .q    (done_s)
  );

  assign link_byte = from_link_s[0] ^ tog_prev_reg;
  assign last_byte = (byte_cnt_reg + 24'h000001) == image_length;
  assign cold_en   = mem_rsp.data[FCL_OPT_COLD_BIT];
  assign vec_addr  = FCL_VEC_BASE + 24'(sel_reg) * FCL_VEC_STRIDE + 24'(vec_idx_reg);

  // ---------------- core clock domain ----------------

  always_ff @(posedge clk) begin
    if (srst || !rst_n_s) begin
      state_reg <= FCL_ST_CLEAR;
    end else begin
      unique case (state_reg)
        FCL_ST_CLEAR: begin
          // host mode never consults the option byte, so no cold boot there
          if (boot_source == FCL_SRC_HOST) begin
            state_reg <= FCL_ST_PERIPH;
          end else begin
            state_reg <= FCL_ST_OPT;
          end
        end
        FCL_ST_OPT: begin
          if (mem_rsp.valid) begin
            state_reg <= cold_en ? FCL_ST_VEC : FCL_ST_LOAD;
          end
        end
        FCL_ST_VEC: begin
          if (mem_rsp.valid && vec_idx_reg == FCL_VEC_LAST) begin
            state_reg <= FCL_ST_LOAD;
          end
        end
        FCL_ST_LOAD: begin
          if (mem_rsp.valid && last_byte) begin
            state_reg <= FCL_ST_DONE;
          end
        end
        FCL_ST_PERIPH: begin
          if (link_byte && last_byte) begin
            state_reg <= FCL_ST_DONE;
          end
        end
        FCL_ST_DONE: begin
          state_reg <= FCL_ST_DONE;
        end
        default: begin
          state_reg <= FCL_ST_CLEAR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      src_reg <= FCL_SRC_ONCHIP;
    end else if (state_reg == FCL_ST_CLEAR) begin
      src_reg <= boot_source;
    end
  end

  // select pins caught once when cold boot turns out enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_reg <= 2'h0;
    end else if (state_reg == FCL_ST_OPT && mem_rsp.valid && cold_en) begin
      sel_reg <= sel_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_reg == FCL_ST_CLEAR) begin
      vec_idx_reg <= 2'h0;
      start_reg   <= 16'h0000;
    end else if (state_reg == FCL_ST_VEC && mem_rsp.valid) begin
      vec_idx_reg <= vec_idx_reg + 2'h1;
      start_reg   <= {start_reg[7:0], mem_rsp.data};
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_reg == FCL_ST_CLEAR) begin
      addr_reg <= FCL_INIT_ADDR;
    end else if (mem_rsp.valid) begin
      unique case (state_reg)
        FCL_ST_OPT: begin
          addr_reg <= FCL_INIT_ADDR;
        end
        FCL_ST_VEC: begin
          if (vec_idx_reg == FCL_VEC_LAST) begin
            addr_reg <= {start_reg, mem_rsp.data};
          end
        end
        FCL_ST_LOAD: begin
          addr_reg <= addr_reg + 24'h000001;
        end
        default: begin
          addr_reg <= addr_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_reg == FCL_ST_CLEAR || state_reg == FCL_ST_OPT) begin
      byte_cnt_reg <= FCL_CNT_RESET;
    end else if ((state_reg == FCL_ST_LOAD && mem_rsp.valid) ||
                 (state_reg == FCL_ST_PERIPH && link_byte)) begin
      byte_cnt_reg <= byte_cnt_reg + 24'h000001;
    end
  end

  // one read outstanding at a time keeps issued and received counts equal
  always_ff @(posedge clk) begin
    if (srst || state_reg == FCL_ST_CLEAR) begin
      pend_reg <= 1'b0;
    end else if (mem_rsp.valid) begin
      pend_reg <= 1'b0;
    end else if (mem_cmd.req) begin
      pend_reg <= 1'b1;
    end
  end

  always_comb begin
    mem_cmd.req       = !pend_reg && (state_reg == FCL_ST_OPT || state_reg == FCL_ST_VEC ||
                                      state_reg == FCL_ST_LOAD);
    mem_cmd.nvm_space = (src_reg == FCL_SRC_ONCHIP);
    mem_cmd.addr      = (state_reg == FCL_ST_VEC) ? vec_addr : addr_reg;
  end

  always_comb begin
    cfg_next.valid = (state_reg == FCL_ST_LOAD && mem_rsp.valid) ||
                     (state_reg == FCL_ST_PERIPH && link_byte);
    cfg_next.data  = (state_reg == FCL_ST_PERIPH) ? hold_reg : mem_rsp.data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_out      <= '0;
      tog_prev_reg <= 1'b0;
    end else begin
      cfg_out      <= cfg_next;
      tog_prev_reg <= from_link_s[0];
    end
  end

  // link logic stays in reset until peripheral mode, while the host is still waiting
  always_ff @(posedge clk) begin
    if (srst || !rst_n_s) begin
      link_rst_reg <= 1'b1;
    end else begin
      link_rst_reg <= !(state_reg == FCL_ST_PERIPH ||
                        (state_reg == FCL_ST_DONE && src_reg == FCL_SRC_HOST));
    end
  end

  assign cfg_clear      = (state_reg == FCL_ST_CLEAR);
  assign config_done_o  = 1'b0;
  assign config_done_oe = (state_reg != FCL_ST_DONE);
  assign spi_so_o       = 1'b0;
  assign spi_so_oe      = 1'b0;

  always_ff @(posedge clk) begin
    if (srst || !rst_n_s) begin
      user_spi_enable <= 1'b0;
    end else begin
      user_spi_enable <= (src_reg == FCL_SRC_HOST) ? from_link_s[1] :
                         (state_reg == FCL_ST_DONE);
    end
  end

  // ---------------- link clock domain ----------------

  assign shift_next = {shift_reg[30:0], spi_mosi};

  // data is taken on the rising edge; the host moves it on the falling one
  always_ff @(posedge spi_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      shift_reg <= 32'h00000000;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge spi_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      synced_reg  <= 1'b0;
      bit_cnt_reg <= 3'h0;
    end else if (!synced_reg) begin
      synced_reg  <= (shift_next == FCL_SYNC_WORD);
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // byte held for eight link clocks, far longer than the core-side sync delay
  always_ff @(posedge spi_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      hold_reg <= 8'h00;
      tog_reg  <= 1'b0;
    end else if (synced_reg && bit_cnt_reg == FCL_BIT_LAST) begin
      hold_reg <= shift_next[7:0];
      tog_reg  <= ~tog_reg;
    end
  end

  always_ff @(posedge spi_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      trail_cnt_reg <= 6'h00;
      handoff_reg   <= 1'b0;
    end else if (done_s && !handoff_reg) begin
      trail_cnt_reg <= trail_cnt_reg + 6'h01;
      if (trail_cnt_reg == FCL_TRAIL_LAST) begin
        handoff_reg <= 1'b1;
      end
    end
  end

  // ---------------- checks ----------------

  AST_SO_UNUSED: assert property (
    @(posedge clk) disable iff (srst) !spi_so_oe)
    else $error("serial data output driven");

  AST_DONE_PIN: assert property (
    @(posedge clk) disable iff (srst)
    (state_reg == FCL_ST_LOAD && mem_rsp.valid && last_byte) |=> !config_done_oe)
    else $error("done pin not released after last byte");

  AST_FIRST_READ: assert property (
    @(posedge clk) disable iff (srst)
    (state_reg == FCL_ST_OPT && mem_cmd.req) |-> mem_cmd.addr == FCL_INIT_ADDR)
    else $error("first read not at initial address");

  AST_NO_COLD: assert property (
    @(posedge clk) disable iff (srst || !rst_n_s)
    (state_reg == FCL_ST_OPT && mem_rsp.valid && !cold_en) |=> state_reg == FCL_ST_LOAD)
    else $error("cold boot taken while disabled");

  AST_VEC_ADDR: assert property (
    @(posedge clk) disable iff (srst)
    (state_reg == FCL_ST_VEC && mem_cmd.req && vec_idx_reg == 2'h0)
      |-> mem_cmd.addr == FCL_VEC_BASE + 24'(sel_reg) * FCL_VEC_STRIDE)
    else $error("vector read at wrong address");

  AST_RESTART: assert property (
    @(posedge clk) disable iff (srst || !rst_n_s)
    (state_reg == FCL_ST_VEC && mem_rsp.valid && vec_idx_reg == FCL_VEC_LAST)
      |=> state_reg == FCL_ST_LOAD && addr_reg == {$past(start_reg), $past(mem_rsp.data)})
    else $error("load did not restart at vector address");

  AST_SEL_HELD: assert property (
    @(posedge clk) disable iff (srst)
    (state_reg == FCL_ST_LOAD && $past(state_reg) == FCL_ST_LOAD) |-> $stable(sel_reg))
    else $error("image select changed during load");

  AST_RESET_RESTART: assert property (
    @(posedge clk) disable iff (srst)
    !rst_n_s |=> state_reg == FCL_ST_CLEAR && cfg_clear && config_done_oe && !user_spi_enable)
    else $error("reset pulse did not restart configuration");

  AST_HUNT: assert property (
    @(posedge spi_sck) disable iff (link_rst_reg)
    !$past(synced_reg) |-> $stable(tog_reg))
    else $error("byte delivered before sync word");

  AST_TRAIL: assert property (
    @(posedge spi_sck) disable iff (link_rst_reg)
    $rose(handoff_reg) |-> $past(trail_cnt_reg) == FCL_TRAIL_LAST)
    else $error("handoff before trailing clocks");

endmodule : fcl_loader
`default_nettype wire

// ==== hw/fcl_pkg.sv ====
// constants and types shared by the configuration loader
//
// Overview of operation
// - load one image: on-chip, flash or host
// - cold boot only in self-load, when enabled
// - cold boot on: sample two image select pins
// - always start with initial image at zero
// - cold boot off: load initial image normally
// - select value indexes one of four vectors
// - vector holds 24-bit image start address
// - restart reading at fetched start address
// - host shifts on fall, device samples rise
// - serial data output stays unused
// - release done once image fully received
// - pins go to user after trailing clocks (self-load hands them over at done)
// - reset pulse restarts whole configuration
package fcl_pkg;

  localparam logic [31:0] FCL_SYNC_WORD    = 32'h7eaa997e;
  localparam logic [23:0] FCL_INIT_ADDR    = 24'h000000;
  localparam logic [23:0] FCL_VEC_BASE     = 24'h000010;
  localparam logic [23:0] FCL_VEC_STRIDE   = 24'h000003;
  localparam logic [1:0]  FCL_VEC_LAST     = 2'h2;
  localparam int          FCL_OPT_COLD_BIT = 0;
  localparam logic [5:0]  FCL_TRAIL_CLOCKS = 6'h31;
  localparam logic [5:0]  FCL_TRAIL_LAST   = FCL_TRAIL_CLOCKS - 6'h01;
  localparam logic [2:0]  FCL_BIT_LAST     = 3'h7;
  localparam logic [23:0] FCL_CNT_RESET    = 24'h000000;

  typedef enum logic [1:0] {
    FCL_SRC_ONCHIP = 2'b00,
    FCL_SRC_FLASH  = 2'b01,
    FCL_SRC_HOST   = 2'b10
  } fcl_src_t;

  typedef enum logic [2:0] {
    FCL_ST_CLEAR  = 3'b000,
    FCL_ST_OPT    = 3'b001,
    FCL_ST_VEC    = 3'b010,
    FCL_ST_LOAD   = 3'b011,
    FCL_ST_PERIPH = 3'b100,
    FCL_ST_DONE   = 3'b101
  } fcl_state_t;

  typedef struct packed {
    logic        req;
    logic        nvm_space;
    logic [23:0] addr;
  } fcl_mem_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fcl_byte_t;

endpackage : fcl_pkg

// ==== hw/fcl_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module fcl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : fcl_sync
`default_nettype wire

// ==== testbench/fcl_host_model.sv ====
// host processor model that streams a configuration image over the serial link
`timescale 1ns/10ps
`default_nettype none
module fcl_host_model #(
  parameter logic [7:0] SHUTOFF_CMD = 8'hb9  // memory shut-off command, value arbitrary
) (
  output logic spi_sck,
  output logic spi_mosi
);
  // clock stands low outside frames
  initial begin
    spi_sck  = 1'b0;
    spi_mosi = 1'b1;
  end

  // data moves while the clock is low, the device samples on the rise
  task automatic send_bit(input logic b);
    spi_mosi = b;
    #24 spi_sck = 1'b1;  // 48 ns period sits inside the 1..25 MHz band
    #24 spi_sck = 1'b0;
  endtask : send_bit

  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
  endtask : send_byte

  // stray bits leave the shut-off byte off any byte boundary
  task automatic send_preamble;
    send_bit(1'b1);
    send_bit(1'b0);
    send_bit(1'b1);
    send_byte(SHUTOFF_CMD);
    send_byte(8'h7e);
    send_byte(8'haa);
    send_byte(8'h99);
    send_byte(8'h7e);
  endtask : send_preamble

  task automatic send_dummy(input int n);
    for (int i = 0; i < n; i++) begin
      send_bit(1'b1);
    end
  endtask : send_dummy

  // released line must not keep showing the last bit
  task automatic end_frame;
    spi_mosi = ~spi_mosi;
  endtask : end_frame
endmodule : fcl_host_model
`default_nettype wire

// ==== testbench/fcl_loader_tb.sv ====
// self-checking bench for the configuration loader
`timescale 1ns/10ps
`default_nettype none
module fcl_loader_tb;
  import fcl_pkg::*;
  localparam int L = 5;
  logic         clk, srst, config_reset_n, spi_sck, spi_mosi, spi_so_o, spi_so_oe;
  logic         cfg_clear, config_done_o, config_done_oe, user_spi_enable;
  logic [1:0]   boot_image_select;
  fcl_src_t     boot_source;
  fcl_mem_req_t mem_cmd;
  fcl_byte_t    mem_rsp, cfg_out;
  logic [7:0]   mem [1024];
  logic         rd_pend = 1'b0;
  logic [9:0]   rd_addr;
  logic [7:0]   got_q [$];
  logic [7:0]   exp_q [$];
  int           num_errors, cmp_count, cycles, wait_cnt, dly;

  fcl_loader i_fcl_loader (.clk(clk), .srst(srst), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .config_reset_n(config_reset_n),
    .boot_image_select(boot_image_select), .boot_source(boot_source),
    .image_length(24'(L)), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .cfg_out(cfg_out),
    .cfg_clear(cfg_clear), .config_done_o(config_done_o), .config_done_oe(config_done_oe),
    .user_spi_enable(user_spi_enable));
  fcl_host_model i_fcl_host_model (.spi_sck(spi_sck), .spi_mosi(spi_mosi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic results;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // the loader raises req for one cycle only, so the address is caught then
  // and answered dly + 1 cycles later
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (mem_cmd.req === 1'b1) begin
      rd_pend  <= 1'b1;
      rd_addr  <= mem_cmd.addr[9:0];
      wait_cnt <= 0;
      check(mem_cmd.nvm_space, boot_source == FCL_SRC_ONCHIP);
    end else if (rd_pend && wait_cnt >= dly) begin
      rd_pend <= 1'b0;
    end else if (rd_pend) begin
      wait_cnt <= wait_cnt + 1;
    end
    mem_rsp.valid <= mem_cmd.req !== 1'b1 && rd_pend && wait_cnt >= dly;
    mem_rsp.data  <= mem[rd_addr];
    if (cfg_out.valid === 1'b1) got_q.push_back(cfg_out.data);
    if (spi_so_oe !== 1'b0) check(spi_so_oe, 1'b0);
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic pulse_reset(input fcl_src_t src, input logic [1:0] sel);
    @(posedge clk);
    boot_source       <= src;
    boot_image_select <= sel;
    config_reset_n    <= 1'b0;
    repeat (5) @(negedge clk);
    check(cfg_clear, 1'b1);
    check(config_done_oe, 1'b1);
    check(config_done_o, 1'b0);
    check(spi_so_o, 1'b0);
    got_q.delete();
    exp_q.delete();
    @(posedge clk);
    config_reset_n <= 1'b1;
  endtask : pulse_reset

  task automatic compare_bytes;
    check(got_q.size(), L);
    foreach (exp_q[i]) check(got_q[i], exp_q[i]);
  endtask : compare_bytes

  task automatic self_boot(input fcl_src_t src, input logic [7:0] opt, input logic [1:0] sel);
    logic [23:0] start;
    start  = opt[0] ? 24'h000040 + 24'(sel) * 24'h000120 : 24'h000000;
    mem[0] = opt;
    pulse_reset(src, sel);
    for (int i = 0; i < L; i++) exp_q.push_back(mem[start[9:0] + 10'(i)]);
    for (int n = 0; n < 300 && config_done_oe !== 1'b0; n++) begin
      @(posedge clk);
      if (got_q.size() == 1) boot_image_select <= ~sel;
    end
    repeat (3) @(negedge clk);
    check(config_done_oe, 1'b0);
    check(user_spi_enable, 1'b1);
    compare_bytes();
  endtask : self_boot

  task automatic host_boot;
    pulse_reset(FCL_SRC_HOST, 2'h0);
    repeat (20) @(posedge clk);
    // keeps link edges off the core clock edges
    #3;
    i_fcl_host_model.send_preamble();
    for (int i = 0; i < L; i++) begin
      exp_q.push_back(8'hc3 ^ 8'(i * 37));
      i_fcl_host_model.send_byte(exp_q[i]);
    end
    repeat (10) @(negedge clk);
    check(config_done_oe, 1'b0);
    check(user_spi_enable, 1'b0);
    // 48 clocks after done must not yet hand the pins over
    i_fcl_host_model.send_dummy(48);
    check(user_spi_enable, 1'b0);
    i_fcl_host_model.send_dummy(7);
    i_fcl_host_model.end_frame();
    repeat (8) @(negedge clk);
    check(user_spi_enable, 1'b1);
    compare_bytes();
  endtask : host_boot

  initial begin
    srst              = 1'b1;
    config_reset_n    = 1'b1;
    boot_image_select = 2'h0;
    boot_source       = FCL_SRC_FLASH;
    num_errors        = 0;
    cmp_count         = 0;
    dly               = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5a ^ 8'(i >> 8);
    // vector entries hold the start address msb first
    for (int s = 0; s < 4; s++) begin
      mem[16 + 3 * s] = 8'h00;
      mem[17 + 3 * s] = 8'((24'h000040 + 24'(s) * 24'h000120) >> 8);
      mem[18 + 3 * s] = 8'(24'h000040 + 24'(s) * 24'h000120);
    end
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      dly = k * 3;
      self_boot(fcl_src_t'(k), 8'hfe, 2'h3);
      for (int s = 0; s < 4; s++) self_boot(fcl_src_t'(k), 8'h01, 2'(s));
    end
    host_boot();
    results();
  end
endmodule : fcl_loader_tb
`default_nettype wire
